// file: hw/ivre_pkg.sv
/*
 * Constants for the indexed-variable and reach-event command unit.
 * Assumes a frame decoder upstream and a reply serializer downstream.
 */
package ivre_pkg;
    localparam int          DATA_W         = 32;
    localparam int          VAR_DEPTH      = 256;
    localparam int          IDX_W          = 8;
    localparam logic [7:0]  OP_GET_IDX     = 8'h38;
    localparam logic [7:0]  OP_ACC_TO_IDX  = 8'h39;
    localparam logic [7:0]  OP_EXT_FIRST   = 8'h40;
    localparam logic [7:0]  OP_EXT_LAST    = 8'h47;
    localparam logic [7:0]  OP_REACH_EVT   = 8'h8a;
    localparam logic [7:0]  ST_OK          = 8'h64;
    localparam logic [7:0]  ST_REACHED     = 8'h80;
    localparam logic [7:0]  ST_BAD_CMD     = 8'h02;
    localparam logic [7:0]  EVT_TYPE_NEXT  = 8'h00;
    localparam logic [7:0]  EVT_TYPE_EVERY = 8'h01;
    localparam int          MASK_BIT       = 0;

    typedef enum logic [1:0] {
        IVRE_EV_OFF,
        IVRE_EV_NEXT,
        IVRE_EV_ARMED,
        IVRE_EV_EVERY
    } ivre_ev_t;
endpackage

// file: hw/ivre_cmd_unit.sv
/*
 * Command execution for indexed user variables, extension opcodes and
 * the target-reached event request of a single-axis motion module.
 * Assumes one command offered per cmd_valid pulse, a reply port that
 * may stall, and a motion core that flags move starts and arrival.
 */
module ivre_cmd_unit
(
    input  wire logic                    clk,
    input  wire logic                    rst,
    // Command in
    input  wire logic                    cmd_valid,
    output logic                         cmd_ready,
    input  wire logic [7:0]              cmd_opcode,
    input  wire logic [7:0]              cmd_type,
    input  wire logic [ivre_pkg::DATA_W-1:0] cmd_value,
    input  wire logic                    cmd_direct,
    // Working registers
    input  wire logic [ivre_pkg::DATA_W-1:0] x_value,
    output logic [ivre_pkg::DATA_W-1:0]  acc_out,
    // Extension hook
    input  wire logic [ivre_pkg::DATA_W-1:0] ext_value,
    // Motion core
    input  wire logic                    move_start,
    input  wire logic                    pos_reached,
    // Reply out
    output logic                         rsp_valid,
    input  wire logic                    rsp_ready,
    output logic [7:0]                   rsp_status,
    output logic [7:0]                   rsp_command,
    output logic [ivre_pkg::DATA_W-1:0]  rsp_value
);
    import ivre_pkg::*;

    // ----------------------------------------
    // Storage and decode
    // ----------------------------------------
    logic [DATA_W-1:0] var_mem [VAR_DEPTH];
    logic [DATA_W-1:0] acc_reg;
    logic              idx_ok;
    logic [IDX_W-1:0]  idx;
    logic              take;
    logic              is_ext;
    logic              evt_pend_reg;
    logic [7:0]        evt_mask_reg;
    ivre_ev_t          ev_reg;
    logic              send_evt;

    assign idx_ok  = (x_value[DATA_W-1:IDX_W] == '0);
    assign idx     = x_value[IDX_W-1:0];
    // An immediate reply must not be pending when a command is taken
    assign cmd_ready = !rsp_valid;
    assign take    = cmd_valid && cmd_ready;
    assign is_ext  = (cmd_opcode >= OP_EXT_FIRST) && (cmd_opcode <= OP_EXT_LAST);
    assign acc_out = acc_reg;

    // ----------------------------------------
    // Variable store and accumulator
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (take && cmd_opcode == OP_ACC_TO_IDX && idx_ok)
        begin
            var_mem[idx] <= acc_reg;
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            acc_reg <= '0;
        end
        else if (take && cmd_opcode == OP_GET_IDX && idx_ok)
        begin
            acc_reg <= var_mem[idx];
        end
    end

    // ----------------------------------------
    // Event arming
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ev_reg       <= IVRE_EV_OFF;
            evt_mask_reg <= '0;
        end
        else if (take && cmd_opcode == OP_REACH_EVT && cmd_direct)
        begin
            evt_mask_reg <= {7'h00, cmd_value[MASK_BIT]};
            if (cmd_type == EVT_TYPE_EVERY)
            begin
                ev_reg <= IVRE_EV_EVERY;
            end
            else
            begin
                ev_reg <= IVRE_EV_NEXT;
            end
        end
        else
        begin
            case (ev_reg)
                IVRE_EV_NEXT:
                begin
                    if (move_start)
                    begin
                        ev_reg <= IVRE_EV_ARMED;
                    end
                end
                IVRE_EV_ARMED:
                begin
                    if (pos_reached)
                    begin
                        ev_reg <= IVRE_EV_OFF;
                    end
                end
                default:
                begin
                    ev_reg <= ev_reg;
                end
            endcase
        end
    end

    // Reached events wait here until the reply port is free
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            evt_pend_reg <= 1'b0;
        end
        else if (pos_reached && evt_mask_reg[MASK_BIT]
                 && (ev_reg == IVRE_EV_ARMED || ev_reg == IVRE_EV_EVERY))
        begin
            evt_pend_reg <= 1'b1;
        end
        else if (send_evt)
        begin
            evt_pend_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // Reply output
    // ----------------------------------------
    // Delayed reply only goes out on an idle port with no command offered
    assign send_evt = evt_pend_reg && !rsp_valid && !cmd_valid;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rsp_valid   <= 1'b0;
            rsp_status  <= '0;
            rsp_command <= '0;
            rsp_value   <= '0;
        end
        else if (rsp_valid)
        begin
            if (rsp_ready)
            begin
                rsp_valid <= 1'b0;
            end
        end
        else if (take)
        begin
            rsp_valid   <= 1'b1;
            rsp_command <= cmd_opcode;
            rsp_value   <= '0;
            if (cmd_opcode == OP_GET_IDX || cmd_opcode == OP_ACC_TO_IDX)
            begin
                rsp_status <= ST_OK;
            end
            else if (is_ext)
            begin
                rsp_status <= ST_OK;
                rsp_value  <= ext_value;
            end
            else if (cmd_opcode == OP_REACH_EVT && cmd_direct)
            begin
                rsp_status <= ST_OK;
                rsp_value  <= {24'h000000, 7'h00, cmd_value[MASK_BIT]};
            end
            else
            begin
                rsp_status <= ST_BAD_CMD;
            end
        end
        else if (send_evt)
        begin
            rsp_valid   <= 1'b1;
            rsp_status  <= ST_REACHED;
            rsp_command <= OP_REACH_EVT;
            rsp_value   <= {24'h000000, evt_mask_reg};
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    get_loads_acc_a: assert property (@(posedge clk) disable iff (rst)
        take && cmd_opcode == OP_GET_IDX && idx_ok |=> acc_reg == $past(var_mem[idx]))
        else $error("accumulator not loaded from variable");
    bad_idx_keep_a: assert property (@(posedge clk) disable iff (rst)
        take && !idx_ok |=> acc_reg == $past(acc_reg))
        else $error("out-of-range index changed accumulator");
    store_keeps_acc_a: assert property (@(posedge clk) disable iff (rst)
        take && cmd_opcode == OP_ACC_TO_IDX |=> acc_reg == $past(acc_reg))
        else $error("store changed accumulator");
    idx_reply_ok_a: assert property (@(posedge clk) disable iff (rst)
        take && cmd_opcode == OP_GET_IDX |=> rsp_valid && rsp_status == ST_OK)
        else $error("indexed command reply not OK");
    ext_reply_a: assert property (@(posedge clk) disable iff (rst)
        take && is_ext |=> rsp_status == ST_OK && rsp_value == $past(ext_value))
        else $error("extension reply wrong");
    stored_evt_reject_a: assert property (@(posedge clk) disable iff (rst)
        take && cmd_opcode == OP_REACH_EVT && !cmd_direct |=> rsp_status == ST_BAD_CMD)
        else $error("event request taken outside direct mode");
    evt_ack_mask_a: assert property (@(posedge clk) disable iff (rst)
        take && cmd_opcode == OP_REACH_EVT && cmd_direct
        |=> rsp_status == ST_OK && rsp_value == {31'h00000000, $past(cmd_value[MASK_BIT])})
        else $error("event request acknowledge wrong");
    once_disarms_a: assert property (@(posedge clk) disable iff (rst)
        ev_reg == IVRE_EV_ARMED && pos_reached && !take |=> ev_reg == IVRE_EV_OFF)
        else $error("single-move event not disarmed");
    every_stays_a: assert property (@(posedge clk) disable iff (rst)
        ev_reg == IVRE_EV_EVERY && !take |=> ev_reg == IVRE_EV_EVERY)
        else $error("every-move event lost");
    reached_frame_a: assert property (@(posedge clk) disable iff (rst)
        send_evt |=> rsp_valid && rsp_status == ST_REACHED && rsp_value[31:8] == '0)
        else $error("reached reply malformed");
    no_interleave_a: assert property (@(posedge clk) disable iff (rst)
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_status) && $stable(rsp_value))
        else $error("reply changed while stalled");
endmodule

// file: bench/ivre_host_model.sv
/*
 * Host side of the reply port: accepts reply frames, stalling at random.
 * Assumes the unit holds each reply until rsp_ready is seen high.
 */
module ivre_host_model
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Reply handshake
    input  wire logic rsp_valid,
    output logic      rsp_ready
);
    timeunit 1ns;
    timeprecision 100ps;

    initial rsp_ready = 1'b0;

    // Ready changes only just after an edge; one cycle in four is a stall
    always @(posedge clk)
    begin
        #1 rsp_ready = !rst && ($urandom_range(3) != 0);
    end
endmodule

// file: bench/tb_indexed_var_and_reach_event_cmds.sv
/*
 * Self-checking bench for the command unit: queue of expected replies.
 * Assumes ivre_pkg and ivre_cmd_unit compiled before this file.
 */
module tb_indexed_var_and_reach_event_cmds;
    timeunit 1ns;
    timeprecision 100ps;
    import ivre_pkg::*;

    logic        clk, rst, cmd_valid, cmd_ready, cmd_direct, move_start, pos_reached;
    logic        rsp_valid, rsp_ready;
    logic [7:0]  cmd_opcode, cmd_type, rsp_status, rsp_command;
    logic [31:0] cmd_value, x_value, acc_out, ext_value, rsp_value, ev;
    logic [48:0] exp_q[$];
    logic [48:0] e;
    logic [31:0] xi;
    int          fail_count, n_checks, cyc;

    ivre_cmd_unit dut (.clk, .rst, .cmd_valid, .cmd_ready, .cmd_opcode, .cmd_type, .cmd_value,
        .cmd_direct, .x_value, .acc_out, .ext_value, .move_start, .pos_reached,
        .rsp_valid, .rsp_ready, .rsp_status, .rsp_command, .rsp_value);
    ivre_host_model host (.clk, .rst, .rsp_valid, .rsp_ready);

    always #12.5 clk = !clk;

    // ----------------------------------------
    // Checking and reporting
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
        n_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            fail_count++;
            final_report;
        end
        else if (!rst && rsp_valid === 1'b1 && rsp_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                chk(32'h1, 32'h0, "unexpected reply");
            else
            begin
                e = exp_q.pop_front();
                chk({16'h0, rsp_status, rsp_command}, {16'h0, e[47:32]}, "status");
                if (e[48])
                    chk(rsp_value, e[31:0], "value");
            end
        end
    end

    // ----------------------------------------
    // Drivers
    // ----------------------------------------
    task automatic send(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] v,
        input logic [31:0] x, input logic dr, input logic [48:0] ex);
        exp_q.push_back(ex);
        cmd_opcode = op;
        cmd_type = ty;
        cmd_value = v;
        x_value = x;
        cmd_direct = dr;
        cmd_valid = 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        #1 cmd_valid = 1'b0;
        // An edge passes so a following call never raises valid in the same step
        @(posedge clk);
        #1;
    endtask

    task automatic reach(input logic mv, input logic ex);
        if (mv)
        begin
            move_start = 1'b1;
            @(posedge clk);
            #1 move_start = 1'b0;
        end
        if (ex)
            exp_q.push_back({1'b1, ST_REACHED, OP_REACH_EVT, 32'h1});
        pos_reached = 1'b1;
        @(posedge clk);
        #1 pos_reached = 1'b0;
        for (int i = 0; i < 60 && exp_q.size() != 0; i++)
            @(posedge clk);
        repeat (4) @(posedge clk);
        #1;
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {clk, cmd_valid, cmd_direct, move_start, pos_reached, cmd_opcode, cmd_type} = '0;
        {cmd_value, x_value, ext_value} = '0;
        rst = 1'b1;
        void'($urandom(62));
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        // Store and load at both end indices and one random index
        for (int i = 0; i < 3; i++)
        begin
            xi = (i == 0) ? 32'h0 : (i == 1) ? 32'hff : 32'($urandom_range(254, 1));
            send(OP_ACC_TO_IDX, 8'h0, 32'h0, xi, 1'b1, {1'b0, ST_OK, OP_ACC_TO_IDX, 32'h0});
            send(OP_GET_IDX, 8'h0, 32'h0, xi, 1'b1, {1'b0, ST_OK, OP_GET_IDX, 32'h0});
            chk(acc_out, 32'h0, "acc");
        end
        send(OP_GET_IDX, 8'h0, 32'h0, 32'h100, 1'b1, {1'b0, ST_OK, OP_GET_IDX, 32'h0});
        send(OP_GET_IDX, 8'h0, 32'h0, 32'hffffffff, 1'b1, {1'b0, ST_OK, OP_GET_IDX, 32'h0});
        chk(acc_out, 32'h0, "acc out of range");
        for (int op = OP_EXT_FIRST; op <= OP_EXT_LAST; op++)
        begin
            ev = $urandom;
            ext_value = ev;
            send(8'(op), 8'($urandom), $urandom, 32'h0, 1'b1, {1'b1, ST_OK, 8'(op), ev});
        end
        send(8'h48, 8'h0, 32'h0, 32'h0, 1'b1, {1'b0, ST_BAD_CMD, 8'h48, 32'h0});
        send(OP_REACH_EVT, EVT_TYPE_EVERY, 32'h1, 32'h0, 1'b0, {1'b0, ST_BAD_CMD, OP_REACH_EVT, 32'h0});
        reach(1'b1, 1'b0);
        send(OP_REACH_EVT, EVT_TYPE_NEXT, 32'h1, 32'h0, 1'b1, {1'b1, ST_OK, OP_REACH_EVT, 32'h1});
        reach(1'b0, 1'b0);
        reach(1'b1, 1'b1);
        reach(1'b1, 1'b0);
        send(OP_REACH_EVT, EVT_TYPE_EVERY, 32'h1, 32'h0, 1'b1, {1'b1, ST_OK, OP_REACH_EVT, 32'h1});
        repeat (3) reach(1'b1, 1'b1);
        reach(1'b0, 1'b1);
        chk(32'(exp_q.size()), 32'h0, "replies missing");
        final_report;
    end
endmodule
